//--- common/hrv_defs.svh
// Constants for the host reset and variable RAM block: register indices,
// field positions, reset values and timing counts.
// Assumes inclusion by bare name from design files that need the map.
`ifndef HRV_DEFS_SVH
`define HRV_DEFS_SVH

// ****************************************************************
// Register map (word indices on reg_addr)
// ****************************************************************
`define HRV_IDX_INPUT_PIN 5'h00
`define HRV_IDX_OUTPUT_LATCH 5'h01
`define HRV_IDX_PIN_DIRECTION 5'h02
`define HRV_IDX_GENERAL_0 5'h03
`define HRV_IDX_GENERAL_12 5'h0F
`define HRV_IDX_TX_DATA 5'h10
`define HRV_IDX_LINK_STATUS 5'h11

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define HRV_STAT_TX_BUSY 0
`define HRV_STAT_RX_LEVEL 1
`define HRV_STAT_IN_CLEAR 2
`define HRV_WORD_RESET 16'h0000
`define HRV_PINS_RELEASED 16'hFFFF

// ****************************************************************
// Timing
// ****************************************************************
`define HRV_CLK_HZ 50000000
`define HRV_BAUD_RATE 9600
`define HRV_BIT_CYCLES (`HRV_CLK_HZ / `HRV_BAUD_RATE)
`define HRV_SUPPLY_MIN_MV 4000

`endif

//--- common/hrv_pkg.sv
// Types for the host reset and variable RAM block.
// Assumes nothing of its surroundings.
package hrv_pkg;

    // Access width of one register operation.
    typedef enum logic [1:0] {
        HRV_SZ_WORD,
        HRV_SZ_BYTE,
        HRV_SZ_NIBBLE,
        HRV_SZ_BIT
    } hrv_size_e;

    // Serial transmitter state.
    typedef enum logic {
        HRV_TX_IDLE,
        HRV_TX_SEND
    } hrv_tx_e;

endpackage

//--- hdl/hrv_top.sv
// Host reset, host serial link and 16-word variable RAM of the interpreter controller.
// Assumes the supply monitor, attention line, serial-in line and I/O pins arrive
// asynchronously, and that a register master on mclk uses the plain strobe port.
//
// The strobed register port and the register addresses were decided locally.
`timescale 1ns/10ps
`include "hrv_defs.svh"

// Function
// - Held in master clear while the supply stays under 4 volts.
// - In reset, execution halts and every I/O line floats.
// - On reset release, program restarts from the first location.
// - Sender idles at 1, starts each character with one 0 bit time.
// - Receive pin is the inverted copy of host serial-in.
// - Serial out drives 0 actively; 1 reuses the host line resting level.
// - Host attention pulls master clear low and resets the controller.
// - After power returns, every variable RAM location except the input word reads zero.
// - Program memory is kept; only downloads or explicit writes change it.
// - RAM is 32 bytes: 6 for I/O control, 26 general.
// - Word order: input, latch, direction, general 0 to 12.
// - Each word accessible as word, byte, nibble or single bit.
// - Direction 1 drives the latch bit; direction 0 floats the pin.
// - Input word reflects pin levels; writes to it do nothing.
// - General word low byte is even, high byte the next odd.
module hrv_top #(
    parameter int BIT_CYCLES = `HRV_BIT_CYCLES,
    parameter int PINS = 16
) (
    input wire logic mclk, // System clock, 50 MHz.
    input wire logic rst, // Asynchronous reset, active high.
    input wire logic [4:0] reg_addr, // Register word index.
    input wire logic [3:0] reg_pos, // Bit position of the accessed field.
    input wire logic [1:0] reg_size, // Access width, hrv_pkg::hrv_size_e.
    input wire logic [15:0] reg_wdata, // Write data, low aligned.
    input wire logic reg_wr, // Write strobe.
    input wire logic reg_rd, // Read strobe.
    output logic [15:0] reg_rdata, // Read data, cycle after the strobe.
    input wire logic supply_low, // Supply monitor: high while under threshold.
    input wire logic host_attention, // Attention line, high when asserted.
    input wire logic host_serial_in, // Host serial-in, high when line positive.
    output logic host_serial_out, // Serial out level, positive when driven.
    output logic host_serial_out_oe_n, // Serial out enable, low while driving.
    input wire logic [PINS-1:0] io_pin_in, // I/O pin levels.
    output logic [PINS-1:0] io_pin_out, // I/O pin drive values.
    output logic [PINS-1:0] io_pin_oe_n, // I/O pin enables, low while driving.
    output logic master_clear_input_n, // Master clear, low while in reset.
    output logic receive_port_pin, // Inverted serial-in seen by the core.
    output logic exec_run, // High while the interpreter runs.
    output logic [10:0] prog_addr // Interpreter program fetch location.
);

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    localparam int SYNC_W = PINS + 3;
    // Supply and attention wake up asserted, so the core stays in clear until
    // the real pin levels have come through the synchroniser after a reset.
    localparam logic [SYNC_W-1:0] SYNC_RST = {3'b011, {PINS{1'b0}}};

    logic [SYNC_W-1:0] sync1_q;
    logic [SYNC_W-1:0] sync2_q;
    logic [SYNC_W-1:0] sync3_q;
    logic [SYNC_W-1:0] filt_q;
    logic [PINS-1:0] pin_level;
    logic supply_low_f;
    logic attention_f;
    logic serial_in_f;
    logic core_clr;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sync1_q <= SYNC_RST;
            sync2_q <= SYNC_RST;
            sync3_q <= SYNC_RST;
        end else begin
            sync1_q <= {host_serial_in, host_attention, supply_low, io_pin_in};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    // A bit takes its new level only once the last two stages agree, which
    // rejects a single-cycle glitch caught on the way in.
    generate
        for (genvar g = 0; g < SYNC_W; g++) begin : g_filt
            always_ff @(posedge mclk or posedge rst) begin
                if (rst) begin
                    filt_q[g] <= SYNC_RST[g];
                end else if (sync2_q[g] == sync3_q[g]) begin
                    filt_q[g] <= sync3_q[g];
                end
            end
        end
    endgenerate

    assign pin_level = filt_q[PINS-1:0];
    assign supply_low_f = filt_q[PINS];
    assign attention_f = filt_q[PINS+1];
    assign serial_in_f = filt_q[PINS+2];

    // ****************************************************************
    // Master clear
    // ****************************************************************
    // Both sources feed one clear so that they act identically.
    assign core_clr = supply_low_f | attention_f;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            master_clear_input_n <= 1'b0;
        end else begin
            master_clear_input_n <= ~core_clr;
        end
    end

    // Program storage lives outside and is only read through prog_addr, so
    // nothing here can disturb it across a clear.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            exec_run <= 1'b0;
            prog_addr <= 11'h000;
        end else if (core_clr) begin
            exec_run <= 1'b0;
            prog_addr <= 11'h000;
        end else begin
            exec_run <= 1'b1;
            if (exec_run) begin
                prog_addr <= prog_addr + 11'h001;
            end
        end
    end

    // ****************************************************************
    // Variable RAM access
    // ****************************************************************
    logic [15:0] ram_q [1:15];
    logic [3:0] shift;
    logic [15:0] mask;
    logic [15:0] sel_word;
    logic [15:0] merged;
    logic ram_hit;
    logic wr_ram;

    always_comb begin
        unique case (hrv_pkg::hrv_size_e'(reg_size))
            hrv_pkg::HRV_SZ_WORD: begin
                shift = 4'h0;
                mask = 16'hFFFF;
            end
            hrv_pkg::HRV_SZ_BYTE: begin
                shift = {reg_pos[3], 3'b000};
                mask = 16'h00FF << shift;
            end
            hrv_pkg::HRV_SZ_NIBBLE: begin
                shift = {reg_pos[3:2], 2'b00};
                mask = 16'h000F << shift;
            end
            hrv_pkg::HRV_SZ_BIT: begin
                shift = reg_pos;
                mask = 16'h0001 << shift;
            end
        endcase
    end

    // Words 0..15 in order input, latch, direction, general 0..12; each
    // general word's low byte is the even byte and its high byte the odd one.
    assign ram_hit = (reg_addr[4] == 1'b0);
    assign sel_word = (reg_addr[3:0] == 4'h0) ? pin_level : ram_q[reg_addr[3:0]];
    assign merged = (sel_word & ~mask) | ((reg_wdata << shift) & mask);
    assign wr_ram = reg_wr && ram_hit && (reg_addr != `HRV_IDX_INPUT_PIN) && !core_clr;

    // Clearing on every master clear covers the power-up case as well.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            for (int i = 1; i < 16; i++) begin
                ram_q[i] <= `HRV_WORD_RESET;
            end
        end else if (core_clr) begin
            for (int i = 1; i < 16; i++) begin
                ram_q[i] <= `HRV_WORD_RESET;
            end
        end else if (wr_ram) begin
            ram_q[reg_addr[3:0]] <= merged;
        end
    end

    // ****************************************************************
    // I/O pin drive
    // ****************************************************************
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            io_pin_out <= '0;
            io_pin_oe_n <= `HRV_PINS_RELEASED;
        end else begin
            io_pin_out <= ram_q[1];
            io_pin_oe_n <= core_clr ? `HRV_PINS_RELEASED : ~ram_q[2];
        end
    end

    // ****************************************************************
    // Host serial link
    // ****************************************************************
    hrv_pkg::hrv_tx_e tx_state_q;
    logic [9:0] tx_shift_q;
    logic [3:0] tx_bits_q;
    logic [15:0] tx_cnt_q;
    logic tx_busy;
    logic tx_load;

    assign tx_busy = (tx_state_q == hrv_pkg::HRV_TX_SEND);
    assign tx_load = reg_wr && (reg_addr == `HRV_IDX_TX_DATA) && !tx_busy && !core_clr;

    // A character is start bit, eight data bits LSB first, then stop bit.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            tx_state_q <= hrv_pkg::HRV_TX_IDLE;
            tx_shift_q <= 10'h3FF;
            tx_bits_q <= 4'h0;
            tx_cnt_q <= 16'h0000;
        end else if (core_clr) begin
            tx_state_q <= hrv_pkg::HRV_TX_IDLE;
            tx_shift_q <= 10'h3FF;
            tx_bits_q <= 4'h0;
            tx_cnt_q <= 16'h0000;
        end else begin
            unique case (tx_state_q)
                hrv_pkg::HRV_TX_IDLE: begin
                    if (tx_load) begin
                        tx_shift_q <= {1'b1, reg_wdata[7:0], 1'b0};
                        tx_bits_q <= 4'h0;
                        tx_cnt_q <= 16'h0000;
                        tx_state_q <= hrv_pkg::HRV_TX_SEND;
                    end
                end
                hrv_pkg::HRV_TX_SEND: begin
                    if (tx_cnt_q == 16'(BIT_CYCLES - 1)) begin
                        tx_cnt_q <= 16'h0000;
                        tx_shift_q <= {1'b1, tx_shift_q[9:1]};
                        if (tx_bits_q == 4'h9) begin
                            tx_state_q <= hrv_pkg::HRV_TX_IDLE;
                        end else begin
                            tx_bits_q <= tx_bits_q + 4'h1;
                        end
                    end else begin
                        tx_cnt_q <= tx_cnt_q + 16'h0001;
                    end
                end
            endcase
        end
    end

    // Only a 0 is driven; a 1 borrows the host line's resting level, which
    // is why the host must stay quiet while we send.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            host_serial_out <= 1'b0;
            host_serial_out_oe_n <= 1'b1;
            receive_port_pin <= 1'b1;
        end else begin
            host_serial_out <= 1'b1;
            host_serial_out_oe_n <= ~(tx_busy && !tx_shift_q[0]);
            receive_port_pin <= ~serial_in_f;
        end
    end

    // ****************************************************************
    // Read port
    // ****************************************************************
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 16'h0000;
        end else if (!reg_rd) begin
            reg_rdata <= 16'h0000;
        end else if (ram_hit) begin
            reg_rdata <= (sel_word & mask) >> shift;
        end else if (reg_addr == `HRV_IDX_LINK_STATUS) begin
            reg_rdata <= 16'h0000;
            reg_rdata[`HRV_STAT_TX_BUSY] <= tx_busy;
            reg_rdata[`HRV_STAT_RX_LEVEL] <= ~serial_in_f;
            reg_rdata[`HRV_STAT_IN_CLEAR] <= core_clr;
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence s_start_bit;
        !host_serial_out_oe_n;
    endsequence

    sequence s_released;
        (io_pin_oe_n == `HRV_PINS_RELEASED) && !exec_run;
    endsequence

    property p_supply_clear;
        supply_low_f |-> ##1 !master_clear_input_n;
    endproperty
    a_supply_clear: assert property (p_supply_clear)
        else $error("Supply low did not hold master clear.");

    property p_release_io;
        core_clr |-> ##1 s_released;
    endproperty
    a_release_io: assert property (p_release_io)
        else $error("Pins not released or core running during clear.");

    property p_restart;
        $rose(exec_run) |-> prog_addr == 11'h000 ##1 prog_addr == 11'h001;
    endproperty
    a_restart: assert property (p_restart)
        else $error("Program did not restart from the first location.");

    property p_start_bit;
        tx_busy && tx_bits_q == 4'h0 |-> ##1 s_start_bit;
    endproperty
    a_start_bit: assert property (p_start_bit)
        else $error("Start bit not driven low at character start.");

    property p_rx_invert;
        ##1 receive_port_pin == !$past(serial_in_f);
    endproperty
    a_rx_invert: assert property (p_rx_invert)
        else $error("Receive pin is not the inverted serial-in.");

    property p_idle_line;
        !tx_busy |-> ##1 host_serial_out_oe_n;
    endproperty
    a_idle_line: assert property (p_idle_line)
        else $error("Serial out driven while idle.");

    property p_attention_clear;
        attention_f |-> ##1 (!master_clear_input_n and s_released);
    endproperty
    a_attention_clear: assert property (p_attention_clear)
        else $error("Attention did not reset the controller.");

    property p_ram_zero;
        core_clr |-> ##1 (ram_q[1] == 16'h0000 && ram_q[15] == 16'h0000);
    endproperty
    a_ram_zero: assert property (p_ram_zero)
        else $error("RAM not cleared after master clear.");

    property p_dir_drive;
        !core_clr |-> ##1 io_pin_oe_n == ~$past(ram_q[2]);
    endproperty
    a_dir_drive: assert property (p_dir_drive)
        else $error("Pin enable does not follow the direction word.");

    property p_input_read;
        reg_rd && reg_addr == `HRV_IDX_INPUT_PIN && reg_size == 2'h0
            |-> ##1 reg_rdata == $past(pin_level);
    endproperty
    a_input_read: assert property (p_input_read)
        else $error("Input word read does not match pin levels.");

endmodule

//--- verification/hrv_host_model.sv
// Behavioural host PC on the far side of the serial link and attention line.
// Assumes one mclk domain and a bit time of BIT clock cycles.
`timescale 1ns/10ps
module hrv_host_model #(
    parameter int BIT = 4
) (
    input wire logic mclk, // System clock.
    input wire logic host_serial_out, // Device drive level.
    input wire logic host_serial_out_oe_n, // Device drive enable, low active.
    output logic host_attention, // Attention line, high when asserted.
    output logic host_serial_in // Host transmit, high when positive.
);
    // The released device output borrows our resting level, so what we
    // receive is only meaningful while we stay quiet.
    logic line_bit;
    assign line_bit = host_serial_out_oe_n ? ~host_serial_in : ~host_serial_out;

    initial begin
        host_attention = 1'b0;
        host_serial_in = 1'b0;
    end

    task automatic set_attn(input logic lvl);
        @(posedge mclk);
        host_attention <= lvl;
    endtask

    task automatic send_byte(input logic [7:0] b);
        int i;
        @(posedge mclk);
        host_serial_in <= 1'b1;
        repeat (BIT) @(posedge mclk);
        for (i = 0; i < 8; i++) begin
            host_serial_in <= ~b[i];
            repeat (BIT) @(posedge mclk);
        end
        host_serial_in <= 1'b0;
    endtask

    task automatic recv_byte(output logic [7:0] b, output logic ok);
        int n;
        int i;
        ok = 1'b0;
        b = 8'h00;
        n = 0;
        while (line_bit !== 1'b0 && n < 200) begin
            @(negedge mclk);
            n++;
        end
        if (n < 200) begin
            repeat (BIT / 2) @(negedge mclk);
            ok = (line_bit === 1'b0);
            for (i = 0; i < 8; i++) begin
                repeat (BIT) @(negedge mclk);
                b[i] = line_bit;
            end
            repeat (BIT) @(negedge mclk);
            ok = ok && (line_bit === 1'b1);
        end
    endtask
endmodule

//--- verification/tb.sv
// Self-checking bench for the host reset, serial link and variable RAM block.
// Assumes the host model and the design files are compiled before it.
`timescale 1ns/10ps
`include "hrv_defs.svh"
module tb;
    localparam int BIT = 4;
    localparam hrv_pkg::hrv_size_e sz_w = hrv_pkg::HRV_SZ_WORD;
    localparam hrv_pkg::hrv_size_e sz_b = hrv_pkg::HRV_SZ_BYTE;
    localparam hrv_pkg::hrv_size_e sz_n = hrv_pkg::HRV_SZ_NIBBLE;
    localparam hrv_pkg::hrv_size_e sz_1 = hrv_pkg::HRV_SZ_BIT;
    localparam logic [4:0] ix_tx = `HRV_IDX_TX_DATA;
    localparam logic [4:0] ix_st = `HRV_IDX_LINK_STATUS;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [4:0] reg_addr = 5'h00;
    logic [3:0] reg_pos = 4'h0;
    logic [1:0] reg_size = 2'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic supply_low = 1'b0;
    logic [15:0] ext = 16'h3C3C;
    logic [15:0] reg_rdata, io_pin_in, io_pin_out, io_pin_oe_n;
    logic host_attention, host_serial_in, host_serial_out, host_serial_out_oe_n;
    logic master_clear_input_n, receive_port_pin, exec_run, ok;
    logic [10:0] prog_addr, pa;
    logic [7:0] rx;
    int error_cnt = 0;
    int num_checks = 0;
    int cyc = 0;
    int i;

    always #10 mclk = ~mclk;
    // A pin shows our drive only where its direction bit enables it.
    assign io_pin_in = (~io_pin_oe_n & io_pin_out) | (io_pin_oe_n & ext);

    hrv_top #(.BIT_CYCLES(BIT), .PINS(16)) dut (
        .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_pos(reg_pos),
        .reg_size(reg_size), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .supply_low(supply_low), .host_attention(host_attention),
        .host_serial_in(host_serial_in), .host_serial_out(host_serial_out),
        .host_serial_out_oe_n(host_serial_out_oe_n), .io_pin_in(io_pin_in),
        .io_pin_out(io_pin_out), .io_pin_oe_n(io_pin_oe_n),
        .master_clear_input_n(master_clear_input_n), .receive_port_pin(receive_port_pin),
        .exec_run(exec_run), .prog_addr(prog_addr));
    hrv_host_model #(.BIT(BIT)) host (
        .mclk(mclk), .host_serial_out(host_serial_out),
        .host_serial_out_oe_n(host_serial_out_oe_n),
        .host_attention(host_attention), .host_serial_in(host_serial_in));

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [4:0] a, input hrv_pkg::hrv_size_e s, input logic [3:0] p,
                      input logic [15:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_size <= s;
        reg_pos <= p;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input string what, input logic [4:0] a, input hrv_pkg::hrv_size_e s,
                      input logic [3:0] p, input logic [15:0] exp);
        @(posedge mclk);
        reg_addr <= a;
        reg_size <= s;
        reg_pos <= p;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        chk(what, exp, reg_rdata);
    endtask

    task automatic wait_mc(input logic lvl);
        int n;
        n = 0;
        while (master_clear_input_n !== lvl && n < 20) begin
            @(negedge mclk);
            n++;
        end
        chk("master clear", {15'h0000, lvl}, {15'h0000, master_clear_input_n});
    endtask

    // Source 0 is the host attention line, source 1 the supply monitor.
    task automatic set_src(input int s, input logic lvl);
        if (s == 0) begin
            host.set_attn(lvl);
        end else begin
            @(posedge mclk);
            supply_low <= lvl;
        end
    endtask

    task automatic test_done;
        $display("Checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            $display("MISMATCH timeout expected finish seen hang");
            test_done;
        end
    end

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial begin
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        wait_mc(1'b1);
        chk("exec run", 16'h0001, {15'h0000, exec_run});
        chk("tx idle", 16'h0001, {15'h0000, host_serial_out_oe_n});
        chk("pins released", 16'hFFFF, io_pin_oe_n);
        for (i = 1; i < 16; i++) rd("ram zero", 5'(i), sz_w, 4'h0, 16'h0000);
        rd("unmapped", 5'h1F, sz_w, 4'h0, 16'h0000);
        $display("test reset done");

        for (i = 3; i < 16; i++) wr(5'(i), sz_w, 4'h0, 16'hA000 | 16'(i));
        for (i = 3; i < 16; i++) rd("word", 5'(i), sz_w, 4'h0, 16'hA000 | 16'(i));
        wr(5'h0F, sz_w, 4'h0, 16'h5A3C);
        rd("low byte", 5'h0F, sz_b, 4'h0, 16'h003C);
        rd("high byte", 5'h0F, sz_b, 4'h8, 16'h005A);
        rd("nibble 1", 5'h0F, sz_n, 4'h4, 16'h0003);
        rd("nibble 3", 5'h0F, sz_n, 4'hC, 16'h0005);
        rd("bit 2", 5'h0F, sz_1, 4'h2, 16'h0001);
        rd("bit 0", 5'h0F, sz_1, 4'h0, 16'h0000);
        wr(5'h03, sz_b, 4'h8, 16'h0077);
        wr(5'h03, sz_n, 4'h4, 16'h000F);
        wr(5'h03, sz_1, 4'h2, 16'h0001);
        rd("merge", 5'h03, sz_w, 4'h0, 16'h77F7);
        $display("test access done");

        wr(5'h01, sz_w, 4'h0, 16'h00A5);
        wr(5'h02, sz_b, 4'h0, 16'h00FF);
        wr(5'h02, sz_1, 4'hC, 16'h0001);
        repeat (2) @(negedge mclk);
        chk("pin enables", 16'hEF00, io_pin_oe_n);
        chk("pin drive", 16'h00A5, io_pin_out);
        wr(5'h00, sz_w, 4'h0, 16'hFFFF);
        repeat (6) @(negedge mclk);
        rd("input word", 5'h00, sz_w, 4'h0, 16'h00A5 | (ext & 16'hEF00));
        rd("input high", 5'h00, sz_b, 4'h8, 16'h002C);
        $display("test pins done");

        wr(ix_tx, sz_w, 4'h0, 16'h00A6);
        fork
            host.recv_byte(rx, ok);
            begin
                repeat (3) @(posedge mclk);
                rd("tx busy", ix_st, sz_w, 4'h0, 16'h0003);
                wr(ix_tx, sz_w, 4'h0, 16'h00FF);
            end
        join
        chk("frame", 16'h0001, {15'h0000, ok});
        chk("tx byte", 16'h00A6, {8'h00, rx});
        repeat (8) @(posedge mclk);
        rd("tx done", ix_st, sz_w, 4'h0, 16'h0002);
        $display("test serial out done");

        for (i = 0; i < 2; i++) begin
            wr(5'h02, sz_w, 4'h0, 16'h10FF);
            set_src(i, 1'b1);
            wait_mc(1'b0);
            chk("pins off", 16'hFFFF, io_pin_oe_n);
            chk("halted", 16'h0000, {15'h0000, exec_run});
            chk("fetch zero", 16'h0000, 16'(prog_addr));
            wr(5'h03, sz_w, 4'h0, 16'h1234);
            rd("clear status", ix_st, sz_w, 4'h0, 16'h0006);
            set_src(i, 1'b0);
            wait_mc(1'b1);
            rd("ram cleared", 5'h03, sz_w, 4'h0, 16'h0000);
            rd("dir cleared", 5'h02, sz_w, 4'h0, 16'h0000);
            chk("running", 16'h0001, {15'h0000, exec_run});
            @(negedge mclk);
            pa = prog_addr;
            repeat (5) @(negedge mclk);
            chk("fetch", 16'(pa + 11'h005), 16'(prog_addr));
        end
        $display("test clear done");

        fork
            host.send_byte(8'h00);
            begin
                repeat (8) @(negedge mclk);
                chk("rx pin", 16'h0000, {15'h0000, receive_port_pin});
                rd("rx level", ix_st, sz_w, 4'h0, 16'h0000);
            end
        join
        repeat (8) @(negedge mclk);
        chk("rx idle", 16'h0001, {15'h0000, receive_port_pin});
        $display("test serial in done");
        test_done;
    end
endmodule
